/* shared/mtp_pkg.sv */
// constants and types shared by the microcode trace port
package mtp_pkg;
    localparam int unsigned MTP_PC_W = 10;
    localparam int unsigned MTP_CODE_W = 4;
    localparam int unsigned MTP_POST_W = 8;
    localparam int unsigned MTP_CORE_W = 2;
    localparam int unsigned MTP_CORES = 4;
    localparam int unsigned MTP_FIFO_DEPTH = 16;
    // calibration burst: eight full periods, each two core clocks
    localparam int unsigned MTP_CAL_PERIODS = 8;
    localparam logic [4:0] MTP_CAL_HALVES = 5'h10;
    // quiet gap after the burst: at least one core clock period
    localparam int unsigned MTP_CLK_NS = 40;
    localparam int unsigned MTP_GAP_NS = 40;
    localparam int unsigned MTP_GAP_CYC = (MTP_GAP_NS + MTP_CLK_NS - 1) / MTP_CLK_NS;
    localparam logic [1:0] MTP_GAP_CNT = 2'(MTP_GAP_CYC);
    localparam logic [MTP_POST_W-1:0] MTP_POST_FOREVER = 8'hff;
    // serial frame on the pin: one start bit then the code bits
    localparam logic [2:0] MTP_FRAME_BITS = 3'h5;
    typedef enum logic [2:0] {
        MTP_IDLE,
        MTP_CAL,
        MTP_GAP,
        MTP_ARMED,
        MTP_TRACE,
        MTP_POST
    } mtp_phase_e;
endpackage : mtp_pkg

/* rtl/mtp_fifo.sv */
// parameterised valid/ready fifo for path codes
`timescale 1ns/1ps
`default_nettype none
module mtp_fifo
    import mtp_pkg::*;
#(
    parameter int unsigned WIDTH = 4,
    parameter int unsigned DEPTH = 16
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } mtp_fptr_s;
    mtp_fptr_s s_q;
    mtp_fptr_s s_d;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic full;
    logic empty;
    logic push;
    logic pop;

    assign full = (s_q.wr[AW] != s_q.rd[AW]) && (s_q.wr[AW-1:0] == s_q.rd[AW-1:0]);
    assign empty = (s_q.wr == s_q.rd);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign push = in_valid_i && !full;
    assign pop = out_ready_i && !empty;
    assign out_data_o = mem_q[s_q.rd[AW-1:0]];

    always_comb begin
        s_d = s_q;
        if (flush_i) begin
            s_d = '0;
        end else begin
            if (push) begin
                s_d.wr = s_q.wr + 1'b1;
            end
            if (pop) begin
                s_d.rd = s_q.rd + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // storage has no reset; only the pointers need a defined value
    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem_q[s_q.wr[AW-1:0]] <= in_data_i;
        end
    end

    a_fifo_no_overrun: assert property (@(posedge core_clk_i) disable iff (rst_i)
        full && !pop && !flush_i |=> full)
        else $error("fifo lost its full state without a pop");
endmodule : mtp_fifo
`default_nettype wire

/* rtl/mtp_serializer.sv */
// shifts framed path codes out on the trace pin
`timescale 1ns/1ps
`default_nettype none
module mtp_serializer
    import mtp_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic code_valid_i,
    output logic code_ready_o,
    input wire logic [MTP_CODE_W-1:0] code_i,
    output logic pin_o,
    output logic busy_o
);
    typedef struct packed {
        logic [MTP_CODE_W:0] shift;
        logic [2:0] left;
        logic pin;
    } mtp_ser_s;
    mtp_ser_s s_q;
    mtp_ser_s s_d;

    assign code_ready_o = enable_i && (s_q.left == 3'h0);
    assign pin_o = s_q.pin;
    assign busy_o = (s_q.left != 3'h0);

    always_comb begin
        s_d = s_q;
        if (!enable_i) begin
            s_d = '0;
        end else if (s_q.left != 3'h0) begin
            s_d.pin = s_q.shift[0];
            s_d.shift = {1'b0, s_q.shift[MTP_CODE_W:1]};
            s_d.left = s_q.left - 3'h1;
        end else if (code_valid_i) begin
            // start bit high, then code lsb first
            s_d.pin = 1'b1;
            s_d.shift = {1'b0, code_i};
            s_d.left = MTP_FRAME_BITS - 3'h1;
        end else begin
            s_d.pin = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    a_ser_frame_len: assert property (@(posedge core_clk_i) disable iff (rst_i)
        code_valid_i && code_ready_o |=> busy_o [*4] ##1 !busy_o)
        else $error("serial frame length is not five bits");
endmodule : mtp_serializer
`default_nettype wire

/* rtl/mtp_trace_port.sv */
// microcode trace port: calibration, start/stop compare, path code stream
// Function
// - enable starts eight-period half-rate calibration burst
// - pin low one clock after burst
// - armed idle unit starts when pc hits start
// - one 4-bit path code per cycle traced
// - host programs start/stop; device compares both
// - pc at stop address enters post-trigger
// - clearing run bit ends tracing early
// - post-trigger runs programmed cycles plus one, then rearms
// - all-ones post length never ends alone
`timescale 1ns/1ps
`default_nettype none
module mtp_trace_port
    import mtp_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic trace_run_i,
    input wire logic [MTP_CORE_W-1:0] core_select_i,
    input wire logic [MTP_PC_W-1:0] trace_start_addr_i,
    input wire logic [MTP_PC_W-1:0] trace_stop_addr_i,
    input wire logic [MTP_POST_W-1:0] post_length_i,
    input wire logic [MTP_CORES*MTP_PC_W-1:0] microcode_program_counter_i,
    input wire logic [MTP_CORES*MTP_CODE_W-1:0] path_code_i,
    output logic debug_trace_pin_o,
    output logic [2:0] trace_phase_o,
    output logic codes_dropped_o
);
    typedef struct packed {
        mtp_phase_e phase;
        logic [4:0] cal_cnt;
        logic [1:0] gap_cnt;
        logic [MTP_POST_W-1:0] post_cnt;
        logic cal_pin;
        logic dropped;
    } mtp_state_s;
    mtp_state_s s_q;
    mtp_state_s s_d;

    logic [MTP_PC_W-1:0] pc_sel;
    logic [MTP_CODE_W-1:0] code_sel;
    logic tracing;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [MTP_CODE_W-1:0] fifo_out_data;
    logic ser_pin;
    logic ser_busy;
    logic stream_on;

    function automatic logic [MTP_PC_W-1:0] pick_pc(
        input logic [MTP_CORES*MTP_PC_W-1:0] all,
        input logic [MTP_CORE_W-1:0] sel
    );
        pick_pc = all[sel*MTP_PC_W +: MTP_PC_W];
    endfunction : pick_pc

    // microcore select mux; reads the cores as a flat vector
    assign pc_sel = pick_pc(microcode_program_counter_i, core_select_i);
    assign code_sel = path_code_i[core_select_i*MTP_CODE_W +: MTP_CODE_W];
    assign tracing = (s_q.phase == MTP_TRACE) || (s_q.phase == MTP_POST);
    // the stream keeps draining after the unit rearms so a short trace is not cut
    assign stream_on = trace_run_i && (tracing || (s_q.phase == MTP_IDLE)
        || (s_q.phase == MTP_ARMED));

    always_comb begin
        s_d = s_q;
        if (tracing && !fifo_in_ready) begin
            s_d.dropped = 1'b1;
        end
        if (!trace_run_i) begin
            s_d.phase = MTP_IDLE;
            s_d.cal_pin = 1'b0;
            s_d.cal_cnt = '0;
        end else begin
            unique case (s_q.phase)
                MTP_IDLE: begin
                    // enable edge: burst only once per run
                    if (!s_q.dropped && s_q.post_cnt == '0) begin
                        s_d.phase = MTP_CAL;
                        s_d.cal_cnt = MTP_CAL_HALVES;
                        s_d.cal_pin = 1'b1;
                        s_d.dropped = 1'b0;
                        s_d.post_cnt = '1;
                    end
                end
                MTP_CAL: begin
                    // toggling every clock gives half the core rate
                    if (s_q.cal_cnt == 5'h1) begin
                        s_d.cal_pin = 1'b0;
                        s_d.phase = MTP_GAP;
                        s_d.gap_cnt = MTP_GAP_CNT;
                    end else begin
                        s_d.cal_pin = !s_q.cal_pin;
                    end
                    s_d.cal_cnt = s_q.cal_cnt - 5'h1;
                end
                MTP_GAP: begin
                    s_d.gap_cnt = s_q.gap_cnt - 2'h1;
                    if (s_q.gap_cnt == 2'h1) begin
                        s_d.phase = MTP_ARMED;
                    end
                end
                MTP_ARMED: begin
                    if (pc_sel == trace_start_addr_i) begin
                        s_d.phase = MTP_TRACE;
                    end
                end
                MTP_TRACE: begin
                    if (pc_sel == trace_stop_addr_i) begin
                        s_d.phase = MTP_POST;
                        s_d.post_cnt = post_length_i;
                    end
                end
                MTP_POST: begin
                    if (post_length_i != MTP_POST_FOREVER) begin
                        if (s_q.post_cnt == '0) begin
                            s_d.phase = MTP_ARMED;
                        end else begin
                            s_d.post_cnt = s_q.post_cnt - 1'b1;
                        end
                    end
                end
            endcase
        end
        // a fresh run bit rearms the burst once the unit is idle
        if (!trace_run_i && s_q.phase == MTP_IDLE) begin
            s_d.post_cnt = '0;
            s_d.dropped = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '{phase: MTP_IDLE, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    mtp_fifo #(
        .WIDTH(MTP_CODE_W),
        .DEPTH(MTP_FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .flush_i(!trace_run_i),
        .in_valid_i(tracing),
        .in_ready_o(fifo_in_ready),
        .in_data_i(code_sel),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    mtp_serializer u_ser (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .enable_i(stream_on),
        .code_valid_i(fifo_out_valid),
        .code_ready_o(fifo_out_ready),
        .code_i(fifo_out_data),
        .pin_o(ser_pin),
        .busy_o(ser_busy)
    );

    // burst and gap own the pin; codes follow only after the gap
    assign debug_trace_pin_o = (s_q.phase == MTP_CAL) ? s_q.cal_pin
        : (s_q.phase == MTP_GAP) ? 1'b0 : ser_pin;
    assign trace_phase_o = 3'(s_q.phase);
    assign codes_dropped_o = s_q.dropped;

    a_cal_burst_toggles: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_q.phase == MTP_IDLE && trace_run_i && s_d.phase == MTP_CAL
        |=> debug_trace_pin_o ##1 !debug_trace_pin_o ##1 debug_trace_pin_o)
        else $error("calibration burst does not toggle at half rate");

    // sixteen half periods, counted as two runs of eight to keep the unroll small
    a_cal_burst_len: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $rose(s_q.phase == MTP_CAL) ##0 trace_run_i [*8] ##1 trace_run_i [*8]
        |=> s_q.phase == MTP_GAP)
        else $error("calibration burst is not sixteen half periods");

    a_cal_half_rate: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_q.phase == MTP_CAL && trace_run_i && s_q.cal_cnt != 5'h1
        |=> debug_trace_pin_o == !$past(debug_trace_pin_o))
        else $error("calibration pin did not toggle every clock");

    a_no_burst_rerun: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_q.phase == MTP_ARMED
        |=> s_q.phase != MTP_CAL)
        else $error("burst repeated without a fresh run bit");

    a_burst_to_gap: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_q.phase == MTP_CAL && trace_run_i && s_q.cal_cnt == 5'h1
        |=> s_q.phase == MTP_GAP && !debug_trace_pin_o)
        else $error("burst did not end in a low gap");

    a_gap_pin_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_q.phase == MTP_GAP
        |-> !debug_trace_pin_o)
        else $error("pin not low after calibration burst");

    a_gap_one_cycle: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_q.phase == MTP_GAP && trace_run_i
        |=> s_q.phase == MTP_ARMED)
        else $error("gap did not end after one clock");

    a_start_compare: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_q.phase == MTP_ARMED && trace_run_i && pc_sel == trace_start_addr_i
        |=> s_q.phase == MTP_TRACE)
        else $error("trace did not start at start address");

    a_no_early_start: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_q.phase == MTP_ARMED && pc_sel != trace_start_addr_i
        |=> s_q.phase != MTP_TRACE)
        else $error("trace started without start address match");

    a_stop_to_post: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_q.phase == MTP_TRACE && trace_run_i && pc_sel == trace_stop_addr_i
        |=> s_q.phase == MTP_POST && s_q.post_cnt == $past(post_length_i))
        else $error("stop address did not enter post-trigger");

    a_no_early_stop: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_q.phase == MTP_TRACE && trace_run_i && pc_sel != trace_stop_addr_i
        |=> s_q.phase == MTP_TRACE)
        else $error("trace left without stop address match");

    a_run_clear_idle: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !trace_run_i
        |=> s_q.phase == MTP_IDLE)
        else $error("clearing run bit did not return to idle");

    a_idle_pin_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_q.phase == MTP_IDLE && !$past(trace_run_i)
        |-> !debug_trace_pin_o)
        else $error("pin not low while idle");

    a_post_count: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_q.phase == MTP_POST && trace_run_i && s_q.post_cnt != '0
        && post_length_i != MTP_POST_FOREVER
        |=> s_q.phase == MTP_POST && s_q.post_cnt == $past(s_q.post_cnt) - 8'h01)
        else $error("post-trigger count did not step down");

    a_post_end: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_q.phase == MTP_POST && trace_run_i && s_q.post_cnt == '0
        && post_length_i != MTP_POST_FOREVER
        |=> s_q.phase == MTP_ARMED)
        else $error("post-trigger did not end after its count");

    a_post_forever: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_q.phase == MTP_POST && trace_run_i && post_length_i == MTP_POST_FOREVER
        |=> s_q.phase == MTP_POST)
        else $error("all-ones post length ended tracing");

    // a push always leaves at least one code queued, even with a pop in the same cycle
    a_code_pushed: assert property (@(posedge core_clk_i) disable iff (rst_i)
        tracing && trace_run_i && fifo_in_ready
        |=> fifo_out_valid)
        else $error("trace cycle queued no path code");

    a_drop_flagged: assert property (@(posedge core_clk_i) disable iff (rst_i)
        tracing && !fifo_in_ready
        |=> codes_dropped_o)
        else $error("lost path code not flagged");

    a_drop_sticky: assert property (@(posedge core_clk_i) disable iff (rst_i)
        codes_dropped_o && trace_run_i
        |=> codes_dropped_o)
        else $error("drop flag cleared while running");

    a_pin_from_stream: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_q.phase == MTP_TRACE
        |-> debug_trace_pin_o == ser_pin)
        else $error("trace pin not driven by the code stream");
endmodule : mtp_trace_port
`default_nettype wire

/* test/mtp_capture_model.sv */
// behavioural capture board: calibrates on the burst, then decodes framed path codes
`timescale 1ns/1ps
`default_nettype none
module mtp_capture_model
    import mtp_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    output logic ready_o,
    output logic code_stb_o,
    output logic [MTP_CODE_W-1:0] code_o
);
    // decoder counters and flags are cleared to zero by the capture reset
    int togg_q;
    int half_q;
    int cnt_q;
    int pos_q;
    logic prev_q;

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            togg_q <= 0;
            half_q <= 0;
            cnt_q <= 0;
            pos_q <= 0;
            prev_q <= 1'b0;
            ready_o <= 1'b0;
            code_stb_o <= 1'b0;
            code_o <= '0;
        end else begin
            code_stb_o <= 1'b0;
            prev_q <= pin_i;
            if (!ready_o) begin
                // bit time is learnt from the first burst half, no shared clock
                if (pin_i != prev_q) togg_q <= togg_q + 1;
                if (togg_q == 0 && pin_i) half_q <= half_q + 1;
                if (togg_q >= 16 && !pin_i) ready_o <= 1'b1;
            end else if (pos_q == 0) begin
                if (pin_i) begin
                    pos_q <= 1;
                    cnt_q <= 1;
                end
            end else if (cnt_q < half_q) begin
                cnt_q <= cnt_q + 1;
            end else begin
                code_o[pos_q-1] <= pin_i;
                cnt_q <= 1;
                if (pos_q == 4) begin
                    code_stb_o <= 1'b1;
                    pos_q <= 0;
                end else begin
                    pos_q <= pos_q + 1;
                end
            end
        end
    end
endmodule : mtp_capture_model
`default_nettype wire

/* test/testbench.sv */
// self-checking bench for the microcode trace port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import mtp_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cap_rst = 1'b1;
    logic run = 1'b0;
    logic [1:0] sel = 2'h0;
    logic [9:0] start_a = 10'h048;
    logic [9:0] stop_a = 10'h071;
    logic [7:0] post = 8'h00;
    logic [39:0] pcs = '0;
    logic [15:0] codes = '0;
    wire logic pin;
    wire logic dropped;
    wire logic ready;
    wire logic stb;
    wire logic [2:0] phase;
    wire logic [3:0] code;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int seed = 31498;
    logic [3:0] exp_q[$];
    logic [3:0] got_q[$];

    mtp_trace_port u_mtp_trace_port (.core_clk_i(clk), .rst_i(rst), .trace_run_i(run),
        .core_select_i(sel), .trace_start_addr_i(start_a), .trace_stop_addr_i(stop_a),
        .post_length_i(post), .microcode_program_counter_i(pcs), .path_code_i(codes),
        .debug_trace_pin_o(pin), .trace_phase_o(phase), .codes_dropped_o(dropped));
    mtp_capture_model u_mtp_capture_model (.core_clk_i(clk), .rst_i(cap_rst), .pin_i(pin),
        .ready_o(ready), .code_stb_o(stb), .code_o(code));

    always #20 clk = ~clk;

    // codes queued on every edge that sees trace or post phase
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (phase == 3'h4 || phase == 3'h5) exp_q.push_back(codes[sel*4+:4]);
        if (stb) got_q.push_back(code);
        if (cycles == 5000) begin
            bad_count++;
            wrap_up();
        end
    end

    task automatic check(string name, logic [31:0] got, logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic tick(int n);
        repeat (n) begin
            @(posedge clk);
            #1;
            codes = 16'($random(seed));
        end
    endtask : tick

    task automatic calibrate();
        cap_rst = 1'b1;
        tick(1);
        cap_rst = 1'b0;
        run = 1'b1;
        tick(1);
        check("cal phase", 32'(phase), 32'h1);
        check("cal pin", 32'(pin), 32'h1);
        for (int i = 1; i < 16; i++) begin
            tick(1);
            check("cal pin", 32'(pin), 32'(i % 2 == 0));
        end
        tick(1);
        check("gap phase", 32'(phase), 32'h2);
        check("gap pin", 32'(pin), 32'h0);
        tick(1);
        check("armed phase", 32'(phase), 32'h3);
        check("ready lamp", 32'(ready), 32'h1);
        exp_q.delete();
        got_q.delete();
    endtask : calibrate

    task automatic wrap_up();
        if (bad_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (2) @(posedge clk);
        check("rst pin", 32'(pin), 32'h0);
        check("rst phase", 32'(phase), 32'h0);
        #1;
        rst = 1'b0;
        sel = 2'($random(seed));
        start_a = 10'($random(seed)) | 10'h200;
        stop_a = start_a ^ 10'h00f;
        post = 8'($random(seed)) & 8'h07;
        calibrate();
        // unselected core at start must not trigger
        pcs[(2'(sel + 2'h1) * 10)+:10] = start_a;
        tick(2);
        check("unselected", 32'(phase), 32'h3);
        pcs = '0;
        pcs[sel*10+:10] = start_a;
        tick(1);
        check("trace phase", 32'(phase), 32'h4);
        pcs[sel*10+:10] = start_a ^ 10'h100;
        tick(5);
        check("no stop yet", 32'(phase), 32'h4);
        pcs[sel*10+:10] = stop_a;
        tick(1);
        check("post phase", 32'(phase), 32'h5);
        pcs[sel*10+:10] = 10'h000;
        tick(int'(post));
        check("post run", 32'(phase), 32'h5);
        tick(1);
        check("post end", 32'(phase), 32'h3);
        for (int i = 0; i < 200 && got_q.size() < exp_q.size(); i++) tick(1);
        check("code count", 32'(got_q.size()), 32'(exp_q.size()));
        foreach (exp_q[i]) check("path code", 32'(got_q[i]), 32'(exp_q[i]));
        check("no drop", 32'(dropped), 32'h0);
        // long trace overflows the fifo, then early stop by clearing the run bit
        pcs[sel*10+:10] = start_a;
        tick(1);
        pcs[sel*10+:10] = start_a ^ 10'h100;
        tick(40);
        check("overflow", 32'(dropped), 32'h1);
        run = 1'b0;
        tick(1);
        check("stop phase", 32'(phase), 32'h0);
        for (int i = 0; i < 10; i++) begin
            tick(1);
            check("idle pin", 32'(pin), 32'h0);
        end
        check("drop clear", 32'(dropped), 32'h0);
        // all-ones post length never ends by itself
        post = MTP_POST_FOREVER;
        calibrate();
        pcs[sel*10+:10] = start_a;
        tick(1);
        pcs[sel*10+:10] = stop_a;
        tick(1);
        check("forever post", 32'(phase), 32'h5);
        pcs[sel*10+:10] = 10'h000;
        tick(300);
        check("still post", 32'(phase), 32'h5);
        run = 1'b0;
        tick(1);
        check("forever stop", 32'(phase), 32'h0);
        check("forever pin", 32'(pin), 32'h0);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
